// ===== core/texture_filter_pkg.sv
// shared constants for the texture filter and bump brightness unit
// assumes a 32-bit axi4-lite register bus with 8-bit byte addresses
package texture_filter_pkg;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL        = 8'h00;
  localparam logic [7:0] OFF_START       = 8'h04;
  localparam logic [7:0] OFF_STATUS      = 8'h08;
  localparam logic [7:0] OFF_LOD         = 8'h0c;
  localparam logic [7:0] OFF_VERTEX      = 8'h10;
  localparam logic [7:0] OFF_OFFSET_COL  = 8'h14;
  localparam logic [7:0] OFF_SECONDARY   = 8'h18;
  localparam logic [7:0] OFF_BUMP_TEXEL  = 8'h1c;
  localparam logic [7:0] OFF_FINE_BASE   = 8'h20;
  localparam logic [7:0] OFF_COARSE_BASE = 8'h30;
  localparam logic [7:0] OFF_RESULT      = 8'h40;
  localparam logic [7:0] OFF_MIP         = 8'h44;

  // control word fields
  localparam int CTRL_MODE_LSB    = 0;
  localparam int CTRL_SS_BIT      = 2;
  localparam int CTRL_BUMP_BIT    = 3;
  localparam int CTRL_SRC_SEL_BIT = 4;
  localparam int CTRL_DST_SEL_BIT = 5;
  localparam int CTRL_STRIP_BIT   = 6;
  localparam logic [31:0] CTRL_MASK = 32'h0000_007f;

  // bump light parameter word and bump texel fields
  localparam int K1_LSB      = 24;
  localparam int K2_LSB      = 16;
  localparam int K3_LSB      = 8;
  localparam int LIGHT_AZ_LSB = 0;
  localparam int ELEV_LSB    = 8;
  localparam int TEXEL_AZ_LSB = 0;

  // level of detail: 4 integer bits over 8 fraction bits
  localparam int LOD_INT_LSB = 8;
  localparam int LOD_W       = 12;

  // values after reset (all registers clear to these)
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

  // super-sampling: four points, sample index bit 0 = +0.5 x, bit 1 = +0.5 y
  localparam logic [1:0] SS_LAST_SAMPLE = 2'h3;
  localparam int         HALF_X_BIT     = 0;
  localparam int         HALF_Y_BIT     = 1;

  // vertex index (zero based) of the third vertex
  localparam logic [7:0] THIRD_VERTEX = 8'h02;

  // angle codes: 255 stands for the full angle 256
  localparam logic [7:0] ANGLE_MAX_CODE = 8'hff;
  localparam logic [8:0] ANGLE_FULL     = 9'h100;
  localparam logic [23:0] WHITE_RGB     = 24'hffffff;

  // quarter-wave trig table shape
  localparam int TRIG_DEPTH = 257;
  localparam int TRIG_AW    = 9;
  localparam int TRIG_DW    = 8;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FILT_POINT, FILT_BILINEAR, FILT_TRI_A, FILT_TRI_B
  } filter_mode_t;

  typedef enum logic [2:0] {
    P_IDLE, P_SAMPLE, P_SIN, P_COS_S, P_COS_D, P_TAKE_D, P_CALC
  } phase_t;

endpackage

// ===== core/bump_trig_rom.sv
// quarter-wave sine table, 0..256 covers 0..90 degrees, 255 means 1.0
// assumes one synchronous read per cycle; data come out of a register
`timescale 1ns/1ps
module bump_trig_rom #(
  parameter int DEPTH = texture_filter_pkg::TRIG_DEPTH,
  parameter int AW    = texture_filter_pkg::TRIG_AW,
  parameter int DW    = texture_filter_pkg::TRIG_DW
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [AW-1:0] addr,
  output logic      [DW-1:0] data
);
  import texture_filter_pkg::*;

  // rational sine approximation, built at elaboration only
  function automatic logic [DW-1:0] quarter_sine(input int i);
    int num;
    int den;
    num = 255 * 16 * i * (512 - i);
    den = 5 * 512 * 512 - 4 * i * (512 - i);
    return DW'((num + den / 2) / den);
  endfunction

  logic [DW-1:0] table_word [DEPTH]; // constant contents
  logic [DW-1:0] next_data;          // word to register

  // fill the table with constants, one entry per step
  for (genvar g = 0; g < DEPTH; g++) begin : g_tab
    assign table_word[g] = quarter_sine(g);
  end

  // out of range addresses read zero rather than garbage
  always_comb begin
    next_data = (int'(addr) < DEPTH) ? table_word[addr] : '0;
  end

  // registered read port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data <= '0;
    end else begin
      data <= next_data;
    end
  end
endmodule

// ===== core/texture_filter_bump_unit.sv
// texture stage: tri-linear passes, super-sampling and bump brightness
// assumes an axi4-lite master on aclk; texel data are written by software
// Overview of operation
// - tri-linear mixes two mip levels, eight texels
// - pass a: fine texel times one minus frac
// - pass b: coarse texel times frac
// - secondary target stores one minus frac alpha
// - source select one copies secondary pixel
// - super-sampling takes four half-pixel spaced points
// - super-sampling reads four times the texels
// - bump brightness from light and normal vectors
// - light word: k1, k2, k3, azimuth bytes
// - light word from third or later vertex
// - bump texel: elevation high, azimuth low
// - bump output white, alpha is brightness
// - angle code 255 counts as full angle
// - brightness k1 + k2 sin + k3 cos cos
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
module texture_filter_bump_unit (
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  input  wire logic [texture_filter_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  input  wire logic [31:0]                         s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  output logic [1:0]                               s_axi_bresp,
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  input  wire logic [texture_filter_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  output logic [31:0]                              s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready
);
  import texture_filter_pkg::*;

  // the whole state of the block
  typedef struct packed {
    logic             aw_full;   // write address held
    logic [7:0]       aw_addr;
    logic             w_full;    // write data held
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [31:0]      ctrl;      // mode, selects, enables
    logic [11:0]      lod;       // level of detail
    logic [7:0]       vertex;    // current vertex index
    logic [31:0]      bump_param; // latched light word
    logic [31:0]      secondary; // secondary buffer pixel
    logic [15:0]      texel;     // bump texel
    logic [3:0][31:0] fine;      // finer level sample per point
    logic [3:0][31:0] coarse;    // coarser level sample per point
    phase_t           phase;
    logic [1:0]       cnt;       // sample point index
    logic [3:0][9:0]  acc_f;     // per channel sums, fine
    logic [3:0][9:0]  acc_c;     // per channel sums, coarse
    logic [7:0]       sin_s;
    logic [7:0]       cos_s;
    logic [7:0]       cos_d;     // magnitude of cos of azimuth difference
    logic             cos_neg;
    logic [31:0]      result;
    logic [7:0]       mip;       // coarse level, fine level
    logic             done;
  } state_t;

  state_t       st;          // registered state
  state_t       next_st;     // next state
  logic [31:0]  read_word;   // read mux output
  logic         read_ok;     // read address mapped
  logic [8:0]   rom_addr;    // trig table address
  logic [7:0]   rom_data;    // trig table word, one cycle late

  // byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // an address lies inside the register map
  function automatic logic mapped(input logic [7:0] a);
    return a[7:2] <= OFF_MIP[7:2];
  endfunction

  // scale a byte by a 0..256 weight
  function automatic logic [7:0] weigh(input logic [7:0] c,
                                       input logic [8:0] w);
    logic [16:0] p;
    p = 17'(c) * 17'(w);
    return p[15:8];
  endfunction

  // product of two fractions coded 255 = 1.0, rounded
  function automatic logic [7:0] scale255(input logic [7:0] a,
                                          input logic [7:0] b);
    logic [16:0] p;
    p = 17'(a) * 17'(b);
    p = p + 17'(p[16:8]) + 17'd128;
    return p[15:8];
  endfunction

  // decoded control fields
  filter_mode_t mode;
  logic         ss_en;
  logic         bump_en;
  logic         src_sel;
  logic         dst_sel;
  logic         strip;
  assign mode    = filter_mode_t'(st.ctrl[CTRL_MODE_LSB +: 2]);
  assign ss_en   = st.ctrl[CTRL_SS_BIT];
  assign bump_en = st.ctrl[CTRL_BUMP_BIT];
  assign src_sel = st.ctrl[CTRL_SRC_SEL_BIT];
  assign dst_sel = st.ctrl[CTRL_DST_SEL_BIT];
  assign strip   = st.ctrl[CTRL_STRIP_BIT];

  // blend weights from the level-of-detail fraction
  logic [7:0] frac;
  logic [8:0] w_a;
  logic [8:0] w_b;
  logic [7:0] tri_alpha;
  assign frac      = st.lod[7:0];
  assign w_a       = 9'h100 - {1'b0, frac};
  assign w_b       = {1'b0, frac};
  assign tri_alpha = (frac == 8'h00) ? 8'hff : w_a[7:0];

  // per channel averages of the sample points and the two pass results
  logic [31:0] avg_f;
  logic [31:0] avg_c;
  logic [31:0] pass_a;
  logic [31:0] pass_b;
  for (genvar ch = 0; ch < 4; ch++) begin : g_ch
    // four points sum into ten bits, so dropping two bits averages them
    assign avg_f[ch*8 +: 8]  = ss_en ? st.acc_f[ch][9:2] : st.acc_f[ch][7:0];
    assign avg_c[ch*8 +: 8]  = ss_en ? st.acc_c[ch][9:2] : st.acc_c[ch][7:0];
    assign pass_a[ch*8 +: 8] = weigh(avg_f[ch*8 +: 8], w_a);
    assign pass_b[ch*8 +: 8] = weigh(avg_c[ch*8 +: 8], w_b);
  end

  // light word and texel fields; code 255 stands for the full angle
  logic [7:0] k1;
  logic [7:0] k2;
  logic [7:0] k3;
  logic [7:0] q_eff;
  logic [7:0] r_eff;
  logic [8:0] s_eff;
  logic [7:0] az_diff;
  assign k1 = st.bump_param[K1_LSB +: 8];
  assign k2 = st.bump_param[K2_LSB +: 8];
  assign k3 = st.bump_param[K3_LSB +: 8];
  // a full turn is the same direction as zero
  assign q_eff = (st.bump_param[LIGHT_AZ_LSB +: 8] == ANGLE_MAX_CODE) ?
                 8'h00 : st.bump_param[LIGHT_AZ_LSB +: 8];
  assign r_eff = (st.texel[TEXEL_AZ_LSB +: 8] == ANGLE_MAX_CODE) ?
                 8'h00 : st.texel[TEXEL_AZ_LSB +: 8];
  assign s_eff = (st.texel[ELEV_LSB +: 8] == ANGLE_MAX_CODE) ?
                 ANGLE_FULL : {1'b0, st.texel[ELEV_LSB +: 8]};
  assign az_diff = r_eff - q_eff;

  // table address per phase; odd quadrants of cos read the table upward
  always_comb begin
    case (st.phase)
      P_SIN:   rom_addr = s_eff;
      P_COS_S: rom_addr = ANGLE_FULL - s_eff;
      P_COS_D: rom_addr = az_diff[6] ? {1'b0, az_diff[5:0], 2'b00} :
                          ANGLE_FULL - {1'b0, az_diff[5:0], 2'b00};
      default: rom_addr = '0;
    endcase
  end

  bump_trig_rom bump_trig_rom_inst (
    .aclk    (aclk),
    .aresetn (aresetn),
    .addr    (rom_addr),
    .data    (rom_data)
  );

  // brightness = k1 + k2 sin(s) + k3 cos(s) cos(r - q), clamped to a byte
  logic [7:0]        term2;
  logic [7:0]        cos_prod;
  logic [7:0]        term3;
  logic signed [10:0] bright_sum;
  logic [7:0]        bright;
  assign term2    = scale255(k2, st.sin_s);
  assign cos_prod = scale255(st.cos_s, st.cos_d);
  assign term3    = scale255(k3, cos_prod);
  assign bright_sum = st.cos_neg ?
      11'(signed'({3'b000, k1})) + 11'(signed'({3'b000, term2})) -
      11'(signed'({3'b000, term3})) :
      11'(signed'({3'b000, k1})) + 11'(signed'({3'b000, term2})) +
      11'(signed'({3'b000, term3}));
  // a sum below zero is darkest, above one is brightest
  assign bright = bright_sum[10] ? 8'h00 :
                  (bright_sum > 11'sd255) ? 8'hff : bright_sum[7:0];

  // read mux; status and results show the block's own state
  always_comb begin
    read_ok   = mapped(s_axi_araddr);
    read_word = '0;
    case (s_axi_araddr[7:2])
      OFF_CTRL[7:2]:       read_word = st.ctrl;
      OFF_STATUS[7:2]:     read_word = {28'h0, st.cnt, st.done,
                                        st.phase != P_IDLE};
      OFF_LOD[7:2]:        read_word = {20'h0, st.lod};
      OFF_VERTEX[7:2]:     read_word = {24'h0, st.vertex};
      OFF_OFFSET_COL[7:2]: read_word = st.bump_param;
      OFF_SECONDARY[7:2]:  read_word = st.secondary;
      OFF_BUMP_TEXEL[7:2]: read_word = {16'h0, st.texel};
      OFF_RESULT[7:2]:     read_word = st.result;
      OFF_MIP[7:2]:        read_word = {24'h0, st.mip};
      default: begin
        // sample slots sit in two blocks of four words
        if (s_axi_araddr[7:4] == OFF_FINE_BASE[7:4]) begin
          read_word = st.fine[s_axi_araddr[3:2]];
        end else if (s_axi_araddr[7:4] == OFF_COARSE_BASE[7:4]) begin
          read_word = st.coarse[s_axi_araddr[3:2]];
        end
      end
    endcase
  end

  // channel handshakes; one write and one read in flight at most
  assign s_axi_awready = !st.aw_full && !st.bvalid;
  assign s_axi_wready  = !st.w_full && !st.bvalid;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;

  // next state: bus slave, register writes and the pixel sequence
  always_comb begin
    logic [31:0] wv;
    next_st = st;
    wv      = merge(32'h0, st.w_data, st.w_strb);
    // address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_full = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = read_ok ? read_word : 32'h0;
      next_st.rresp  = read_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    // pixel sequence; a start while busy is ignored
    case (st.phase)
      P_IDLE: begin
        next_st.cnt = '0;
      end
      P_SAMPLE: begin
        // one sample point per cycle, so four cycles with super-sampling
        for (int ch = 0; ch < 4; ch++) begin
          next_st.acc_f[ch] = st.acc_f[ch] + 10'(st.fine[st.cnt][ch*8 +: 8]);
          next_st.acc_c[ch] = st.acc_c[ch] + 10'(st.coarse[st.cnt][ch*8 +: 8]);
        end
        next_st.cnt = st.cnt + 2'h1;
        if (!ss_en || st.cnt == SS_LAST_SAMPLE) begin
          next_st.phase = (bump_en && !src_sel) ? P_SIN : P_CALC;
        end
      end
      P_SIN: begin
        next_st.phase = P_COS_S;
      end
      P_COS_S: begin
        next_st.sin_s = rom_data;
        next_st.phase = P_COS_D;
      end
      P_COS_D: begin
        next_st.cos_s   = rom_data;
        next_st.cos_neg = az_diff[7] ^ az_diff[6];
        next_st.phase   = P_TAKE_D;
      end
      P_TAKE_D: begin
        next_st.cos_d = rom_data;
        next_st.phase = P_CALC;
      end
      P_CALC: begin
        if (src_sel) begin
          next_st.result = st.secondary;
        end else if (bump_en) begin
          next_st.result = {bright, WHITE_RGB};
        end else begin
          case (mode)
            FILT_TRI_A: next_st.result =
                {dst_sel ? tri_alpha : pass_a[31:24], pass_a[23:0]};
            FILT_TRI_B: next_st.result =
                {dst_sel ? tri_alpha : pass_b[31:24], pass_b[23:0]};
            default:    next_st.result = avg_f;
          endcase
        end
        // integer part picks the finer level, the next one up is coarser
        next_st.mip[3:0] = st.lod[LOD_INT_LSB +: 4];
        next_st.mip[7:4] = (st.lod[LOD_INT_LSB +: 4] == 4'hf) ? 4'hf :
                           st.lod[LOD_INT_LSB +: 4] + 4'h1;
        next_st.done  = 1'b1;
        next_st.phase = P_IDLE;
      end
      default: begin
        next_st.phase = P_IDLE;
      end
    endcase

    // register write once both halves are held
    if (st.aw_full && st.w_full && !st.bvalid) begin
      next_st.aw_full = 1'b0;
      next_st.w_full  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = mapped(st.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      case (st.aw_addr[7:2])
        OFF_CTRL[7:2]:      next_st.ctrl = merge(st.ctrl, st.w_data, st.w_strb) & CTRL_MASK;
        OFF_LOD[7:2]:       next_st.lod = LOD_W'(merge({20'h0, st.lod}, st.w_data,
                                                        st.w_strb));
        OFF_VERTEX[7:2]:    next_st.vertex = wv[7:0] | (st.vertex & ~{8{st.w_strb[0]}});
        OFF_SECONDARY[7:2]: next_st.secondary = merge(st.secondary, st.w_data, st.w_strb);
        OFF_BUMP_TEXEL[7:2]: next_st.texel = 16'(merge({16'h0, st.texel}, st.w_data,
                                                       st.w_strb));
        OFF_OFFSET_COL[7:2]: begin
          // only the third vertex, or later ones in a strip, carry the light word
          if (st.vertex == THIRD_VERTEX || (strip && st.vertex > THIRD_VERTEX)) begin
            next_st.bump_param = merge(st.bump_param, st.w_data, st.w_strb);
          end
        end
        OFF_START[7:2]: begin
          // start clears done; only taken when idle, so no finish can collide
          if (st.phase == P_IDLE) begin
            next_st.phase = P_SAMPLE;
            next_st.done  = 1'b0;
            next_st.acc_f = '0;
            next_st.acc_c = '0;
            next_st.cnt   = '0;
          end
        end
        default: begin
          // sample slots; status, result and level words are read only
          if (st.aw_addr[7:4] == OFF_FINE_BASE[7:4]) begin
            next_st.fine[st.aw_addr[3:2]] =
                merge(st.fine[st.aw_addr[3:2]], st.w_data, st.w_strb);
          end else if (st.aw_addr[7:4] == OFF_COARSE_BASE[7:4]) begin
            next_st.coarse[st.aw_addr[3:2]] =
                merge(st.coarse[st.aw_addr[3:2]], st.w_data, st.w_strb);
          end
        end
      endcase
    end
  end

  // state register; every field clears on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// ===== test/texture_filter_properties.sv
// assertions on the register port of the texture filter unit
// assumes the bind below; sees only the unit's ports
`timescale 1ns/1ps
module texture_filter_properties
  import texture_filter_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid
);
  logic [7:0]  wa, ra;   // addresses of the write and read under way
  logic [31:0] ctl, sec; // shadow of control word and secondary pixel
  logic        ran;      // started since control last changed
  wire         wt = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
  // shadow only writes whose address and data are taken in one cycle; a read before the run ends would look stale
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {wa, ra, ctl, sec, ran} <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
      if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
      if (wt && s_axi_awaddr == OFF_CTRL) ctl <= s_axi_wdata;
      if (wt && s_axi_awaddr == OFF_SECONDARY) sec <= s_axi_wdata;
      if (wt) ran <= (s_axi_awaddr == OFF_START) | (ran & (s_axi_awaddr != OFF_CTRL));
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (wt |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer off time");
  a_write_resp: assert property ($rose(s_axi_bvalid) |->
    s_axi_bresp == (wa >= 8'h48 ? RESP_SLVERR : RESP_OKAY)) else $error("bad write resp");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid &&
    s_axi_rresp == (ra >= 8'h48 ? RESP_SLVERR : RESP_OKAY)) else $error("bad read answer");
  a_mip_order: assert property (s_axi_rvalid && ra == OFF_MIP |-> s_axi_rdata[7:4] ==
    (s_axi_rdata[3:0] == 4'hf ? 4'hf : s_axi_rdata[3:0] + 4'h1)) else $error("bad levels");
  a_flush_copy: assert property (s_axi_rvalid && ra == OFF_RESULT && ran && ctl[4]
    |-> s_axi_rdata == sec) else $error("secondary not copied");
  a_bump_white: assert property (s_axi_rvalid && ra == OFF_RESULT && ran && ctl[3]
    && !ctl[4] |-> s_axi_rdata[23:0] == WHITE_RGB) else $error("bump colour not white");
  c_bump: cover property (s_axi_rvalid && ran && ctl[3]);
  c_flush: cover property (s_axi_rvalid && ran && ctl[4]);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
bind texture_filter_bump_unit texture_filter_properties texture_filter_properties_inst (.*);

// ===== test/host_pass_list.sv
// host model: control word of each pass of a tri-linear polygon
// assumes the control layout of the unit's package
`timescale 1ns/1ps
module host_pass_list (
  input  wire logic [1:0]  pass,
  output logic      [31:0] ctrl
);
  // blend factors and lists live outside the unit, so only selects show
  always_comb begin
    case (pass)
      2'h0:    ctrl = 32'h0000_0002;
      2'h1:    ctrl = 32'h0000_0003;
      2'h2:    ctrl = 32'h0000_0022;
      default: ctrl = 32'h0000_0010;
    endcase
  end
endmodule

// ===== test/tb_texture_filter_bump_unit.sv
// self-checking bench for the texture filter unit over its register port
// assumes the unit, its package and the host pass model are compiled first
`timescale 1ns/1ps
module tb_texture_filter_bump_unit;
  import texture_filter_pkg::*;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, hctl, rdat;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rrsp, pass = '0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int          errors = 0, n_compared = 0;
  texture_filter_bump_unit texture_filter_bump_unit_inst (.*);
  host_pass_list host_pass_list_inst (.pass(pass), .ctrl(hctl));
  always #4 aclk = ~aclk;
  // sample at the falling edge so what is seen holds at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(negedge aclk);
      ta = s_axi_awready & s_axi_awvalid;
      tw = s_axi_wready & s_axi_wvalid;
      tb = s_axi_bvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end while (!tb);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tv;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(negedge aclk);
      ta = s_axi_arready;
      tv = s_axi_rvalid;
      {rdat, rrsp} = {s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
    end while (!tv);
    s_axi_rready <= 1'h0;
  endtask
  task automatic chk(input logic [31:0] g, e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask
  // start a run and poll done a bounded number of times
  task automatic go;
    wr(OFF_START, 32'h1);
    rdat = '0;
    repeat (20) if (!rdat[1]) rd(OFF_STATUS);
    chk({31'h0, rdat[1]}, 32'h1);
  endtask
  // lod 1.25: fine level 1, weight 0x40 of 256
  task automatic t_tri;
    logic [31:0] ex [3] = '{32'h60606060, 32'h10101010, 32'hc0606060};
    wr(OFF_LOD, 32'h140);
    wr(OFF_FINE_BASE, 32'h80808080);
    wr(OFF_COARSE_BASE, 32'h40404040);
    for (int p = 0; p < 3; p++) begin
      pass = p[1:0];
      #1 wr(OFF_CTRL, hctl);
      go();
      rc(OFF_RESULT, ex[p]);
    end
    // levels are only chosen once a pass has run
    rc(OFF_MIP, 32'h21);
    // translucent pass b into the secondary buffer also stores one minus frac
    wr(OFF_CTRL, 32'h23);
    go();
    rc(OFF_RESULT, 32'hc0101010);
  endtask
  task automatic t_flush;
    wr(OFF_SECONDARY, 32'h12345678);
    pass = 2'h3;
    #1 wr(OFF_CTRL, hctl);
    go();
    rc(OFF_RESULT, 32'h12345678);
  endtask
  // four differing points average, a lone point is used as is
  task automatic t_ss;
    for (int k = 0; k < 4; k++) wr(OFF_FINE_BASE + 8'(4 * k), 32'h04040404 * (k + 1));
    for (int m = 0; m < 3; m++) begin
      wr(OFF_CTRL, m == 2 ? 32'h1 : 32'h4 | m);
      go();
      rc(OFF_RESULT, m == 2 ? 32'h04040404 : 32'h0a0a0a0a);
    end
  endtask
  task automatic t_bump;
    wr(OFF_VERTEX, 32'h0);
    wr(OFF_OFFSET_COL, 32'h11223344);
    rc(OFF_OFFSET_COL, 32'h0);
    wr(OFF_VERTEX, 32'h2);
    wr(OFF_OFFSET_COL, 32'h10ff0000);
    wr(OFF_BUMP_TEXEL, 32'hff00);
    wr(OFF_CTRL, 32'h8);
    go();
    rc(OFF_RESULT, 32'hffffffff);
    wr(OFF_VERTEX, 32'h3);
    wr(OFF_CTRL, 32'h48);
    wr(OFF_OFFSET_COL, 32'h40000000);
    go();
    rc(OFF_RESULT, 32'h40ffffff);
  endtask
  task automatic t_err;
    wr(8'h4c, 32'h1);
    rc(8'h48, 32'h0);
    chk({30'h0, rrsp}, {30'h0, RESP_SLVERR});
  endtask
  task automatic test_done;
    if (errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    t_tri();
    t_flush();
    t_ss();
    t_bump();
    t_err();
    test_done();
  end
  // whole run is a few hundred cycles
  initial begin
    #100us;
    errors++;
    test_done();
  end
endmodule
